//--- sdi_pkg.sv
// Shared constants for the south display interrupt and hot plug block
package sdi_pkg;
	localparam logic [7:0]  OFF_LIVE_STATUS  = 8'h00;
	localparam logic [7:0]  OFF_SOURCE_MASK  = 8'h04;
	localparam logic [7:0]  OFF_IDENTITY     = 8'h08;
	localparam logic [7:0]  OFF_OUT_ENABLE   = 8'h0C;
	localparam logic [7:0]  OFF_HOT_PLUG     = 8'h30;
	localparam logic [31:0] RST_SOURCE_MASK  = 32'h0FFFFFFF;
	localparam logic [31:0] RST_ZERO         = 32'h00000000;
	localparam int          BIT_D_BUF_ON     = 20;
	localparam int          POS_D_THRESH     = 18;
	localparam int          POS_D_RESULT     = 16;
	localparam int          BIT_C_BUF_ON     = 12;
	localparam int          POS_C_THRESH     = 10;
	localparam int          POS_C_RESULT     = 8;
	localparam int          SRC_PORT_D       = 23;
	localparam int          SRC_PORT_C       = 22;
	localparam int          SRC_LINK_RX_C    = 8;
	localparam int          SRC_LINK_RX_B    = 4;
	localparam int          SRC_PROT_REQ_C   = 10;
	localparam int          SRC_PROT_CHG_C   = 9;
	localparam int          SRC_PROT_REQ_B   = 6;
	localparam int          SRC_PROT_REQ_A   = 2;
	localparam int          SRC_PROT_CHG_A   = 1;
	localparam logic [31:0] SRC_DRIVEN_MASK  = 32'h00C00756;
	localparam logic [31:0] SRC_RESERVED_MASK = 32'h1115F888;
	localparam int          CLK_MHZ          = 200;
	localparam int          T_2MS_US         = 2000;
	localparam int          T_4P5MS_US       = 4500;
	localparam int          T_6MS_US         = 6000;
	localparam int          T_100MS_US       = 100000;
	localparam int          CYC_2MS          = T_2MS_US * CLK_MHZ;
	localparam int          CYC_4P5MS        = T_4P5MS_US * CLK_MHZ;
	localparam int          CYC_6MS          = T_6MS_US * CLK_MHZ;
	localparam int          CYC_100MS        = T_100MS_US * CLK_MHZ;
	localparam int          CNT_W            = 25;
endpackage

//--- sdi_pulse_classifier.sv
// Hot plug detect pulse timer for one port
`timescale 1ns/1ps
`default_nettype none
module sdi_pulse_classifier #(
	parameter int CYC_2MS   = sdi_pkg::CYC_2MS,
	parameter int CYC_4P5MS = sdi_pkg::CYC_4P5MS,
	parameter int CYC_6MS   = sdi_pkg::CYC_6MS,
	parameter int CYC_100MS = sdi_pkg::CYC_100MS
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	input  wire logic       pin_i,
	input  wire logic       buf_on_i,
	input  wire logic [1:0] thresh_i,
	output logic            short_o,
	output logic            long_o
);
	typedef enum logic {SDI_IDLE, SDI_LOW} sdi_state_t;
	sdi_state_t state_reg;
	logic [sdi_pkg::CNT_W-1:0] cnt_reg;
	logic [sdi_pkg::CNT_W-1:0] limit;
	wire  pin_low = buf_on_i & ~pin_i;
	wire  ended   = (state_reg == SDI_LOW) & ~pin_low;
	always_comb begin
		unique case (thresh_i)
			2'h0: limit = sdi_pkg::CNT_W'(CYC_2MS);
			2'h1: limit = sdi_pkg::CNT_W'(CYC_4P5MS);
			2'h2: limit = sdi_pkg::CNT_W'(CYC_6MS);
			2'h3: limit = sdi_pkg::CNT_W'(CYC_100MS);
		endcase
	end
	// Short below threshold, long otherwise
	assign short_o = ended & (cnt_reg < limit);
	assign long_o  = ended & (cnt_reg >= limit);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= SDI_IDLE;
			cnt_reg   <= '0;
		end else if (ce_i) begin
			unique case (state_reg)
				SDI_IDLE: begin
					// Count includes the first low cycle
					cnt_reg <= {{(sdi_pkg::CNT_W-1){1'b0}}, pin_low};
					if (pin_low) state_reg <= SDI_LOW;
				end
				SDI_LOW: begin
					if (!pin_low) state_reg <= SDI_IDLE;
					else if (cnt_reg != '1) cnt_reg <= cnt_reg + 1'b1;
				end
			endcase
		end
	end
endmodule // sdi_pulse_classifier
`default_nettype wire

//--- sdi_irq_hotplug.sv
// South display interrupt aggregation and hot plug detect control
`timescale 1ns/1ps
`default_nettype none
module sdi_irq_hotplug #(
	parameter int CYC_2MS   = sdi_pkg::CYC_2MS,
	parameter int CYC_4P5MS = sdi_pkg::CYC_4P5MS,
	parameter int CYC_6MS   = sdi_pkg::CYC_6MS,
	parameter int CYC_100MS = sdi_pkg::CYC_100MS
) (
	input  wire logic        REF_CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        CLK_EN_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	input  wire logic [7:0]  REG_ADDR_I,
	input  wire logic [31:0] REG_WDATA_I,
	output logic      [31:0] REG_RDATA_O,
	input  wire logic [31:0] EXT_SOURCES_I,
	input  wire logic        PORT_D_HOT_PLUG_DETECT_I,
	input  wire logic        PORT_C_HOT_PLUG_DETECT_I,
	input  wire logic [7:0]  LINK_RX_STATUS_BITS_C_I,
	input  wire logic [7:0]  LINK_RX_STATUS_BITS_B_I,
	input  wire logic        AUDIO_PROTECT_REQUEST_A_I,
	input  wire logic        AUDIO_PROTECT_REQUEST_B_I,
	input  wire logic        AUDIO_PROTECT_REQUEST_C_I,
	output logic             DISPLAY_IRQ_O
);
	logic [31:0] live_status_vector_reg;
	logic [31:0] source_mask_vector_reg;
	logic [31:0] sticky_identity_vector_reg;
	logic [31:0] sticky_identity_vector_next;
	logic [31:0] queued_reg;
	logic [31:0] queued_next;
	logic [31:0] hold_low_reg;
	logic [31:0] output_enable_vector_reg;
	logic [31:0] prev_status_reg;
	logic [1:0]  port_d_threshold_reg;
	logic [1:0]  port_c_threshold_reg;
	logic        port_d_buf_on_reg;
	logic        port_c_buf_on_reg;
	logic [1:0]  port_d_detect_result_reg;
	logic [1:0]  port_c_detect_result_reg;
	logic [1:0]  hpd_d_sync_reg;
	logic [1:0]  hpd_c_sync_reg;
	logic        prot_a_reg;
	logic        prot_c_reg;
	logic [31:0] rdata_reg;
	logic        irq_reg;
	logic        d_short;
	logic        d_long;
	logic        c_short;
	logic        c_long;

	wire sel_live  = REG_ADDR_I == sdi_pkg::OFF_LIVE_STATUS;
	wire sel_mask  = REG_ADDR_I == sdi_pkg::OFF_SOURCE_MASK;
	wire sel_ident = REG_ADDR_I == sdi_pkg::OFF_IDENTITY;
	wire sel_en    = REG_ADDR_I == sdi_pkg::OFF_OUT_ENABLE;
	wire sel_hp    = REG_ADDR_I == sdi_pkg::OFF_HOT_PLUG;
	wire wr_mask   = CLK_EN_I & REG_WR_I & sel_mask;
	wire wr_ident  = CLK_EN_I & REG_WR_I & sel_ident;
	wire wr_en     = CLK_EN_I & REG_WR_I & sel_en;
	wire wr_hp     = CLK_EN_I & REG_WR_I & sel_hp;

	// Detect pins cross into the core clock through two flops
	wire hpd_d = hpd_d_sync_reg[1];
	wire hpd_c = hpd_c_sync_reg[1];

	sdi_pulse_classifier #(
		.CYC_2MS   (CYC_2MS),
		.CYC_4P5MS (CYC_4P5MS),
		.CYC_6MS   (CYC_6MS),
		.CYC_100MS (CYC_100MS)
	) u_class_d (
		.clk_i    (REF_CLK_I),
		.rst_n_i  (RESETN_I),
		.ce_i     (CLK_EN_I),
		.pin_i    (hpd_d),
		.buf_on_i (port_d_buf_on_reg),
		.thresh_i (port_d_threshold_reg),
		.short_o  (d_short),
		.long_o   (d_long)
	);

	sdi_pulse_classifier #(
		.CYC_2MS   (CYC_2MS),
		.CYC_4P5MS (CYC_4P5MS),
		.CYC_6MS   (CYC_6MS),
		.CYC_100MS (CYC_100MS)
	) u_class_c (
		.clk_i    (REF_CLK_I),
		.rst_n_i  (RESETN_I),
		.ce_i     (CLK_EN_I),
		.pin_i    (hpd_c),
		.buf_on_i (port_c_buf_on_reg),
		.thresh_i (port_c_threshold_reg),
		.short_o  (c_short),
		.long_o   (c_long)
	);

	// Result bits: set wins over a write-one clear
	wire [1:0] d_result_next = (port_d_detect_result_reg & ~(wr_hp ? REG_WDATA_I[17:16] : 2'h0))
		| {d_long, d_short};
	wire [1:0] c_result_next = (port_c_detect_result_reg & ~(wr_hp ? REG_WDATA_I[9:8] : 2'h0))
		| {c_long, c_short};

	// Source vector assembled from the owned sources and the external ones
	logic [31:0] own_sources;
	always_comb begin
		own_sources = 32'h00000000;
		own_sources[sdi_pkg::SRC_PORT_D]     = |port_d_detect_result_reg;
		own_sources[sdi_pkg::SRC_PORT_C]     = |port_c_detect_result_reg;
		own_sources[sdi_pkg::SRC_LINK_RX_C]  = |LINK_RX_STATUS_BITS_C_I;
		own_sources[sdi_pkg::SRC_LINK_RX_B]  = |LINK_RX_STATUS_BITS_B_I;
		own_sources[sdi_pkg::SRC_PROT_REQ_C] = AUDIO_PROTECT_REQUEST_C_I;
		own_sources[sdi_pkg::SRC_PROT_REQ_B] = AUDIO_PROTECT_REQUEST_B_I;
		own_sources[sdi_pkg::SRC_PROT_REQ_A] = AUDIO_PROTECT_REQUEST_A_I;
		own_sources[sdi_pkg::SRC_PROT_CHG_C] = AUDIO_PROTECT_REQUEST_C_I ^ prot_c_reg;
		own_sources[sdi_pkg::SRC_PROT_CHG_A] = AUDIO_PROTECT_REQUEST_A_I ^ prot_a_reg;
	end
	wire [31:0] status_now = own_sources
		| (EXT_SOURCES_I & ~sdi_pkg::SRC_DRIVEN_MASK & ~sdi_pkg::SRC_RESERVED_MASK);

	// Per-bit rising edge event gated by the mask
	wire [31:0] event_now = status_now & ~prev_status_reg & ~source_mask_vector_reg;
	wire [31:0] clr_bits  = wr_ident ? REG_WDATA_I : 32'h00000000;

	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_ident
			always_comb begin
				sticky_identity_vector_next[g] = sticky_identity_vector_reg[g];
				queued_next[g] = queued_reg[g];
				if (sticky_identity_vector_reg[g]) begin
					if (clr_bits[g]) begin
						sticky_identity_vector_next[g] = 1'b0;
						queued_next[g] = queued_reg[g] | event_now[g];
					end else if (event_now[g]) begin
						queued_next[g] = 1'b1;
					end
				end else if (hold_low_reg[g]) begin
					sticky_identity_vector_next[g] = 1'b1;
					queued_next[g] = event_now[g];
				end else if (event_now[g]) begin
					sticky_identity_vector_next[g] = 1'b1;
				end
			end
		end
	endgenerate

	// A queued bit cleared now returns high one cycle later
	wire [31:0] hold_low_next = sticky_identity_vector_reg & clr_bits & queued_next;

	assign DISPLAY_IRQ_O = irq_reg;

	wire [31:0] hp_view = {11'h000, port_d_buf_on_reg, port_d_threshold_reg, port_d_detect_result_reg,
		3'h0, port_c_buf_on_reg, port_c_threshold_reg, port_c_detect_result_reg, 8'h00};
	wire [31:0] rd_mux = sel_live  ? live_status_vector_reg :
		sel_mask  ? source_mask_vector_reg :
		sel_ident ? sticky_identity_vector_reg :
		sel_en    ? output_enable_vector_reg :
		sel_hp    ? hp_view : 32'h00000000;

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			hpd_d_sync_reg <= 2'h3;
			hpd_c_sync_reg <= 2'h3;
		end else if (CLK_EN_I) begin
			hpd_d_sync_reg <= {hpd_d_sync_reg[0], PORT_D_HOT_PLUG_DETECT_I};
			hpd_c_sync_reg <= {hpd_c_sync_reg[0], PORT_C_HOT_PLUG_DETECT_I};
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			live_status_vector_reg     <= sdi_pkg::RST_ZERO;
			prev_status_reg            <= sdi_pkg::RST_ZERO;
			sticky_identity_vector_reg <= sdi_pkg::RST_ZERO;
			queued_reg                 <= sdi_pkg::RST_ZERO;
			hold_low_reg               <= sdi_pkg::RST_ZERO;
			prot_a_reg                 <= 1'b0;
			prot_c_reg                 <= 1'b0;
			irq_reg                    <= 1'b0;
			rdata_reg                  <= sdi_pkg::RST_ZERO;
		end else if (CLK_EN_I) begin
			live_status_vector_reg     <= status_now;
			prev_status_reg            <= status_now;
			sticky_identity_vector_reg <= sticky_identity_vector_next;
			queued_reg                 <= queued_next;
			hold_low_reg               <= hold_low_next;
			prot_a_reg                 <= AUDIO_PROTECT_REQUEST_A_I;
			prot_c_reg                 <= AUDIO_PROTECT_REQUEST_C_I;
			irq_reg                    <= |(sticky_identity_vector_next & output_enable_vector_reg);
			if (REG_RD_I) rdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			source_mask_vector_reg   <= sdi_pkg::RST_SOURCE_MASK;
			output_enable_vector_reg <= sdi_pkg::RST_ZERO;
			port_d_buf_on_reg        <= 1'b0;
			port_c_buf_on_reg        <= 1'b0;
			port_d_threshold_reg     <= 2'h0;
			port_c_threshold_reg     <= 2'h0;
			port_d_detect_result_reg <= 2'h0;
			port_c_detect_result_reg <= 2'h0;
		end else if (CLK_EN_I) begin
			if (wr_mask) source_mask_vector_reg <= REG_WDATA_I;
			if (wr_en) output_enable_vector_reg <= REG_WDATA_I;
			if (wr_hp) begin
				port_d_buf_on_reg    <= REG_WDATA_I[sdi_pkg::BIT_D_BUF_ON];
				port_c_buf_on_reg    <= REG_WDATA_I[sdi_pkg::BIT_C_BUF_ON];
				port_d_threshold_reg <= REG_WDATA_I[sdi_pkg::POS_D_THRESH +: 2];
				port_c_threshold_reg <= REG_WDATA_I[sdi_pkg::POS_C_THRESH +: 2];
			end
			port_d_detect_result_reg <= d_result_next;
			port_c_detect_result_reg <= c_result_next;
		end
	end

	assign REG_RDATA_O = rdata_reg;
endmodule // sdi_irq_hotplug
`default_nettype wire

//--- sdi_north_model.sv
// North side model that records rising edges of the combined interrupt
`timescale 1ns/1ps
`default_nettype none
module sdi_north_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       irq_i,
	output logic      [7:0] rise_cnt_o
);
	logic irq_reg;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_reg    <= 1'b0;
			rise_cnt_o <= 8'h00;
		end else begin
			irq_reg <= irq_i;
			if (irq_i && !irq_reg) rise_cnt_o <= rise_cnt_o + 8'h01;
		end
	end
endmodule // sdi_north_model
`default_nettype wire

//--- sdi_irq_hotplug_props.sv
// Port checker for the south display interrupt block
`timescale 1ns/1ps
`default_nettype none
module sdi_irq_hotplug_props (
	input wire logic        REF_CLK_I,
	input wire logic        RESETN_I,
	input wire logic        CLK_EN_I,
	input wire logic        REG_WR_I,
	input wire logic        REG_RD_I,
	input wire logic [7:0]  REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic [31:0] REG_RDATA_O,
	input wire logic [7:0]  LINK_RX_STATUS_BITS_C_I,
	input wire logic        AUDIO_PROTECT_REQUEST_B_I,
	input wire logic        DISPLAY_IRQ_O
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RESETN_I);
	logic [31:0] mask_reg, en_reg, ctl_reg;
	wire rd_w = CLK_EN_I && REG_RD_I;
	wire wr_w = CLK_EN_I && REG_WR_I;
	wire rd_live = rd_w && REG_ADDR_I == sdi_pkg::OFF_LIVE_STATUS;
	wire clr_w = wr_w && (REG_ADDR_I == sdi_pkg::OFF_IDENTITY || REG_ADDR_I == sdi_pkg::OFF_OUT_ENABLE);
	wire mapped = REG_ADDR_I inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h30};
	// Shadow copies of the plain read-write registers
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mask_reg <= sdi_pkg::RST_SOURCE_MASK;
			en_reg   <= 32'h00000000;
			ctl_reg  <= 32'h00000000;
		end else if (wr_w) begin
			if (REG_ADDR_I == sdi_pkg::OFF_SOURCE_MASK) mask_reg <= REG_WDATA_I;
			if (REG_ADDR_I == sdi_pkg::OFF_OUT_ENABLE) en_reg <= REG_WDATA_I;
			if (REG_ADDR_I == sdi_pkg::OFF_HOT_PLUG) ctl_reg <= REG_WDATA_I & 32'h001C1C00;
		end
	end
	unmapped_zero_a: assert property (rd_w && !mapped |=> REG_RDATA_O == 32'h00000000)
		else $error("unmapped read not zero");
	live_link_a: assert property ((CLK_EN_I && |LINK_RX_STATUS_BITS_C_I) [*3] ##0 rd_live |=> REG_RDATA_O[8])
		else $error("link source bit low");
	live_prot_a: assert property ((CLK_EN_I && $stable(AUDIO_PROTECT_REQUEST_B_I)) [*3] ##0 rd_live
		|=> REG_RDATA_O[6] == $past(AUDIO_PROTECT_REQUEST_B_I, 2))
		else $error("request level wrong");
	irq_fall_a: assert property ($fell(DISPLAY_IRQ_O) |-> $past(clr_w) || $past(clr_w, 2))
		else $error("irq fell without write");
	irq_quiet_a: assert property (en_reg == 32'h0 && $past(en_reg) == 32'h0 |-> !DISPLAY_IRQ_O)
		else $error("irq with all disabled");
	mask_rb_a: assert property (rd_w && REG_ADDR_I == sdi_pkg::OFF_SOURCE_MASK |=> REG_RDATA_O == $past(mask_reg))
		else $error("mask readback wrong");
	en_rb_a: assert property (rd_w && REG_ADDR_I == sdi_pkg::OFF_OUT_ENABLE |=> REG_RDATA_O == $past(en_reg))
		else $error("enable readback wrong");
	ctl_rb_a: assert property (rd_w && REG_ADDR_I == sdi_pkg::OFF_HOT_PLUG
		|=> (REG_RDATA_O & 32'hFFFCFCFF) == $past(ctl_reg))
		else $error("hot plug control wrong");
	cover property ($rose(DISPLAY_IRQ_O));
	cover property (clr_w ##1 !DISPLAY_IRQ_O ##1 DISPLAY_IRQ_O);
	cover property (rd_w && REG_ADDR_I == sdi_pkg::OFF_HOT_PLUG ##1 |REG_RDATA_O[17:16]);
endmodule // sdi_irq_hotplug_props
bind sdi_irq_hotplug sdi_irq_hotplug_props props (.REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I),
	.CLK_EN_I(CLK_EN_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
	.REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .LINK_RX_STATUS_BITS_C_I(LINK_RX_STATUS_BITS_C_I),
	.AUDIO_PROTECT_REQUEST_B_I(AUDIO_PROTECT_REQUEST_B_I), .DISPLAY_IRQ_O(DISPLAY_IRQ_O));
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the south display interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, irq;
	logic pd = 1'b1, pc = 1'b1, aa = 1'b0, ab = 1'b0, ac = 1'b0;
	logic [7:0]  addr = 8'h00, lc = 8'h00, lb = 8'h00, rises;
	logic [31:0] wdat = 32'h0, ext = 32'h0, rdat, got;
	logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h30, 8'h40};
	int          thr [4] = '{20, 45, 60, 100};
	int          err_total = 0;
	int          num_checks = 0;
	sdi_irq_hotplug #(.CYC_2MS(20), .CYC_4P5MS(45), .CYC_6MS(60), .CYC_100MS(100)) dut (
		.REF_CLK_I(clk), .RESETN_I(rst_n), .CLK_EN_I(ce), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdat), .REG_RDATA_O(rdat), .EXT_SOURCES_I(ext),
		.PORT_D_HOT_PLUG_DETECT_I(pd), .PORT_C_HOT_PLUG_DETECT_I(pc), .LINK_RX_STATUS_BITS_C_I(lc),
		.LINK_RX_STATUS_BITS_B_I(lb), .AUDIO_PROTECT_REQUEST_A_I(aa), .AUDIO_PROTECT_REQUEST_B_I(ab),
		.AUDIO_PROTECT_REQUEST_C_I(ac), .DISPLAY_IRQ_O(irq));
	sdi_north_model north (.clk_i(clk), .rst_n_i(rst_n), .irq_i(irq), .rise_cnt_o(rises));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdat = d;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		got = rdat;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(input bit port_c, input int n);
		if (port_c) pc = 1'b0;
		else pd = 1'b0;
		cyc(n);
		{pc, pd} = 2'b11;
		cyc(8);
	endtask
	function automatic logic [31:0] live_exp();
		return (ext & ~(sdi_pkg::SRC_DRIVEN_MASK | sdi_pkg::SRC_RESERVED_MASK))
			| {21'h0, ac, 1'b0, |lc, 1'b0, ab, 1'b0, |lb, 1'b0, aa, 2'b00};
	endfunction
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		final_report();
	end
	initial begin : main
		logic [31:0] e;
		int b, t, n, p, hb;
		void'($urandom(32'hA01E));
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		wreg(sdi_pkg::OFF_LIVE_STATUS, 32'hFFFFFFFF);
		wreg(8'h40, 32'hFFFFFFFF);
		for (int i = 0; i < 6; i++) begin
			rreg(offs[i]);
			chk("reset value", got, i == 1 ? sdi_pkg::RST_SOURCE_MASK : 32'h0);
		end
		wreg(sdi_pkg::OFF_SOURCE_MASK, 32'hFFFFFFFF);
		for (int i = 0; i < 20; i++) begin
			ext = $urandom();
			lc = (i % 3 == 0) ? 8'h00 : 8'($urandom());
			lb = 8'($urandom()) & {8{i[0]}};
			{aa, ab} = 2'($urandom());
			ac = i[1];
			cyc(3);
			rreg(sdi_pkg::OFF_LIVE_STATUS);
			chk("live status", got, live_exp());
		end
		{ext, lc, lb, aa, ab, ac} = '0;
		cyc(3);
		repeat (2) wreg(sdi_pkg::OFF_IDENTITY, 32'hFFFFFFFF);
		wreg(sdi_pkg::OFF_SOURCE_MASK, ~32'h00000202);
		{aa, ac} = 2'b11;
		cyc(3);
		rreg(sdi_pkg::OFF_IDENTITY);
		chk("change events", got, 32'h00000202);
		{aa, ac} = 2'b00;
		cyc(3);
		repeat (2) wreg(sdi_pkg::OFF_IDENTITY, 32'hFFFFFFFF);
		do b = $urandom_range(31, 0); while (sdi_pkg::SRC_DRIVEN_MASK[b] || sdi_pkg::SRC_RESERVED_MASK[b]);
		wreg(sdi_pkg::OFF_SOURCE_MASK, ~(32'h1 << b));
		repeat (2) begin
			ext[b] = 1'b1;
			cyc(1);
			ext[b] = 1'b0;
			cyc(2);
		end
		rreg(sdi_pkg::OFF_IDENTITY);
		chk("identity", got, 32'h1 << b);
		chk("irq disabled", {31'h0, irq}, 32'h0);
		wreg(sdi_pkg::OFF_OUT_ENABLE, 32'h1 << b);
		cyc(2);
		wreg(sdi_pkg::OFF_IDENTITY, ~(32'h1 << b));
		cyc(2);
		chk("irq enabled", {31'h0, irq}, 32'h1);
		e = {24'h0, rises};
		wreg(sdi_pkg::OFF_IDENTITY, 32'h1 << b);
		p = 0;
		for (int i = 0; i < 4; i++) begin
			p += !irq;
			cyc(1);
		end
		chk("irq dip", 32'(p), 32'h1);
		chk("irq again", {31'h0, irq}, 32'h1);
		chk("north edges", {24'h0, rises}, e + 32'h1);
		wreg(sdi_pkg::OFF_IDENTITY, 32'h1 << b);
		cyc(2);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		ce = 1'b0;
		wreg(sdi_pkg::OFF_OUT_ENABLE, 32'h0);
		ce = 1'b1;
		rreg(sdi_pkg::OFF_OUT_ENABLE);
		chk("frozen enable", got, 32'h1 << b);
		ext[b] = 1'b1;
		cyc(3);
		wreg(sdi_pkg::OFF_IDENTITY, 32'h1 << b);
		cyc(3);
		rreg(sdi_pkg::OFF_IDENTITY);
		chk("level once", got, 32'h0);
		ext[b] = 1'b0;
		for (int i = 0; i < 16; i++) begin
			p = i[0];
			t = i[2:1];
			n = thr[t] - 1 + i[3];
			hb = p ? sdi_pkg::BIT_C_BUF_ON : sdi_pkg::BIT_D_BUF_ON;
			e = (32'h1 << hb) | (32'(t) << (hb - 2)) | (32'h3 << (hb - 4));
			wreg(sdi_pkg::OFF_HOT_PLUG, e | (32'h3 << sdi_pkg::POS_D_RESULT) | (32'h3 << sdi_pkg::POS_C_RESULT));
			pulse(p[0], n);
			rreg(sdi_pkg::OFF_HOT_PLUG);
			chk("detect result", got, e ^ ((i[3] ? 32'h1 : 32'h2) << (hb - 4)));
			rreg(sdi_pkg::OFF_LIVE_STATUS);
			chk("hot plug source", got, 32'h1 << (p ? sdi_pkg::SRC_PORT_C : sdi_pkg::SRC_PORT_D));
		end
		wreg(sdi_pkg::OFF_HOT_PLUG, e & ~(32'h3 << (hb - 4)));
		rreg(sdi_pkg::OFF_HOT_PLUG);
		chk("result held", got, e ^ (32'h1 << (hb - 4)));
		wreg(sdi_pkg::OFF_HOT_PLUG, 32'h3 << (hb - 4));
		pulse(1'b1, 30);
		rreg(sdi_pkg::OFF_HOT_PLUG);
		chk("buffer off", got, 32'h0);
		final_report();
	end
endmodule // tb_top
`default_nettype wire
